// >>> event_reg.sv
`timescale 1ns/10ps
`include "swi_defs.svh"
// sticky status, clear on read, mask and a level interrupt
module event_reg #(parameter int W = 7) (
  input wire logic clock,
  input wire logic reset,
  swi_link_if.evt_side lk
);
  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] mask_q;
  logic [W-1:0] mask_d;
  logic irq_q;

  // =====================================================================
  // a set in the cycle of the clearing read wins, so no event is lost
  assign status_d = (lk.clr_rd ? '0 : status_q) | lk.ev_set;
  assign mask_d = lk.mask_we ? lk.mask_wd : mask_q;
  assign lk.status = status_q;
  assign lk.mask = mask_q;
  assign lk.irq = irq_q;

  // status, mask and interrupt level update together
  always_ff @(posedge clock) begin
    if (reset) begin
      status_q <= '0;
      mask_q <= W'(`MASK_RST);
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end
endmodule

// >>> flag_stack.sv
`timescale 1ns/10ps
// lifo of saved stack-select state, one entry per accepted interrupt while not full
module flag_stack #(parameter int DEPTH = 8, parameter int W = 2) (
  input wire logic clock,
  input wire logic reset,
  swi_link_if.stk_side lk
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] top_cnt;

  // =====================================================================
  // flags and top of stack
  assign top_cnt = cnt_q - CW'(1);
  assign lk.full = (cnt_q == CW'(DEPTH));
  assign lk.empty = (cnt_q == '0);
  assign lk.top_data = mem_q[top_cnt[AW-1:0]];

  // fill level; a push into a full stack is dropped and reported upstream
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (lk.push && !lk.full) begin
      cnt_q <= cnt_q + CW'(1);
    end else if (lk.pop && !lk.empty) begin
      cnt_q <= top_cnt;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge clock) begin
    if (lk.push && !lk.full) begin
      mem_q[cnt_q[AW-1:0]] <= lk.push_data;
    end
  end
endmodule

// >>> software_interrupt_unit_bench.sv
`timescale 1ns/10ps
module software_interrupt_unit_bench import swi_pkg::*;;
  // =====================================================================
  // stimulus and observed signals
  logic clock = 1'b0, reset = 1'b1, instr_done = 1'b0, alu_done = 1'b0, alu_ov = 1'b0;
  logic gate_flag = 1'b0, irq_req = 1'b0, nmi_req = 1'b0, u_wr = 1'b0, u_wdata = 1'b0;
  logic reg_we = 1'b0, reg_re = 1'b0, redirect_brk = 1'b0, slow = 1'b0, vec_valid;
  instr_class_e instr_class = cls_none;
  alu_op_e alu_op = op_other;
  logic [5:0] int_num = 6'h00;
  logic [2:0] cpu_level = 3'h0, irq_level = 3'h0;
  logic [4:0] irq_num = 5'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, vec_rdata, reg_rdata;
  logic stall, vec_req, handler_valid, irq_ack, stack_sel, ov_flag, irq, ack_q;
  logic [19:0] vec_addr, handler_addr;
  int miscompares = 0, n_tests = 0, cycles = 0;

  swi_trap_unit i_dut (.clock(clock), .reset(reset), .instr_done(instr_done),
    .instr_class(instr_class), .int_num(int_num), .alu_done(alu_done), .alu_op(alu_op),
    .alu_ov(alu_ov), .gate_flag(gate_flag), .cpu_level(cpu_level), .irq_req(irq_req),
    .irq_level(irq_level), .irq_num(irq_num), .nmi_req(nmi_req), .u_wr(u_wr),
    .u_wdata(u_wdata), .vec_rdata(vec_rdata), .vec_valid(vec_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .stall(stall), .vec_req(vec_req), .vec_addr(vec_addr), .handler_valid(handler_valid),
    .handler_addr(handler_addr), .irq_ack(irq_ack), .stack_sel(stack_sel),
    .ov_flag(ov_flag), .irq(irq));
  vec_mem_model i_mem (.clock(clock), .reset(reset), .vec_req(vec_req), .vec_addr(vec_addr),
    .redirect_brk(redirect_brk), .slow(slow), .vec_valid(vec_valid), .vec_rdata(vec_rdata));

  always #4 clock = ~clock;

  // =====================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample there
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic instr(input instr_class_e c, input logic [5:0] n);
    @(posedge clock);
    instr_done <= 1'b1;
    instr_class <= c;
    int_num <= n;
    @(posedge clock);
    instr_done <= 1'b0;
    instr_class <= cls_none;
    #1;
  endtask
  task automatic alu(input alu_op_e op, input logic ov, input logic exp);
    @(posedge clock);
    alu_done <= 1'b1;
    alu_op <= op;
    alu_ov <= ov;
    @(posedge clock);
    alu_done <= 1'b0;
    #1;
    check(32'(ov_flag), 32'(exp));
  endtask
  // one full acceptance: first fetch, stack flag, last fetch and handler word
  task automatic take(input instr_class_e c, input logic [5:0] n, input logic [19:0] first,
                      input logic [19:0] last, input logic sel);
    int k = 0;
    instr(c, n);
    ack_q = irq_ack;
    check(32'(vec_req), 32'h1);
    check(32'(vec_addr), 32'(first));
    check(32'(stack_sel), 32'(sel));
    while (handler_valid !== 1'b1 && k < 40) begin
      @(posedge clock);
      #1;
      k++;
    end
    check(32'(stall), 32'h0);
    check(32'(vec_addr), 32'(last));
    check(32'(handler_addr), 32'(last ^ 20'h5a5a5));
  endtask
  task automatic ret(input logic sel);
    instr(cls_return, 6'h00);
    check(32'(stack_sel), 32'(sel));
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset();
    reg_chk(8'h0c, 32'h8);
    reg_chk(8'h04, 32'h0);
    reg_chk(8'h08, 32'h0);
    reg_chk(8'h10, 32'h0);
    check({29'h0, stack_sel, ov_flag, irq}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_vcall();
    reg_wr(8'h08, 32'h00001003);
    reg_chk(8'h08, 32'h00001000);
    reg_wr(8'h04, 32'h7f);
    @(posedge clock);
    u_wr <= 1'b1;
    u_wdata <= 1'b1;
    @(posedge clock);
    u_wr <= 1'b0;
    take(cls_vec_call, 6'd5, 20'h01014, 20'h01014, 1'b0);
    @(posedge clock);
    #1;
    check(32'(irq), 32'h1);
    reg_chk(8'h00, 32'h8);
    check(32'(irq), 32'h0);
    ret(1'b1);
    take(cls_vec_call, 6'd63, 20'h010fc, 20'h010fc, 1'b1);
    ret(1'b1);
    take(cls_vec_call, 6'd31, 20'h0107c, 20'h0107c, 1'b0);
    ret(1'b1);
    take(cls_vec_call, 6'd32, 20'h01080, 20'h01080, 1'b1);
    ret(1'b1);
    reg_chk(8'h00, 32'h8);
    $display("test vector call done");
  endtask
  task automatic t_traps();
    slow <= 1'b1;
    take(cls_undef, 6'd0, 20'hfffdc, 20'hfffdc, 1'b1);
    ret(1'b1);
    alu(op_logic, 1'b1, 1'b0);
    instr(cls_ovf_trap, 6'd0);
    check({30'h0, vec_req, stall}, 32'h0);
    alu(op_add, 1'b1, 1'b1);
    take(cls_ovf_trap, 6'd0, 20'hfffe0, 20'hfffe0, 1'b1);
    ret(1'b1);
    alu(op_sub, 1'b0, 1'b0);
    take(cls_break, 6'd0, 20'hfffe4, 20'hfffe4, 1'b1);
    ret(1'b1);
    redirect_brk <= 1'b1;
    take(cls_break, 6'd0, 20'hfffe4, 20'h01000, 1'b1);
    ret(1'b1);
    redirect_brk <= 1'b0;
    slow <= 1'b0;
    reg_chk(8'h00, 32'h7);
    $display("test traps done");
  endtask
  task automatic t_irq();
    irq_req <= 1'b1;
    irq_level <= 3'h5;
    cpu_level <= 3'h2;
    irq_num <= 5'h07;
    instr(cls_none, 6'd0);
    check(32'(vec_req), 32'h0);
    gate_flag <= 1'b1;
    irq_level <= 3'h2;
    instr(cls_none, 6'd0);
    check(32'(vec_req), 32'h0);
    irq_level <= 3'h5;
    nmi_req <= 1'b1;
    take(cls_none, 6'd0, 20'hffff8, 20'hffff8, 1'b1);
    check(32'(ack_q), 32'h0);
    nmi_req <= 1'b0;
    take(cls_none, 6'd0, 20'h0101c, 20'h0101c, 1'b0);
    check(32'(ack_q), 32'h1);
    irq_req <= 1'b0;
    ret(1'b1);
    ret(1'b1);
    gate_flag <= 1'b0;
    cpu_level <= 3'h7;
    nmi_req <= 1'b1;
    take(cls_none, 6'd0, 20'hffff8, 20'hffff8, 1'b1);
    nmi_req <= 1'b0;
    ret(1'b1);
    reg_chk(8'h00, 32'h30);
    reg_wr(8'h04, 32'h0);
    take(cls_undef, 6'd0, 20'hfffdc, 20'hfffdc, 1'b1);
    ret(1'b1);
    check(32'(irq), 32'h0);
    reg_wr(8'h04, 32'h1);
    @(posedge clock);
    #1;
    check(32'(irq), 32'h1);
    reg_chk(8'h00, 32'h1);
    check(32'(irq), 32'h0);
    $display("test interrupts done");
  endtask
  task automatic t_nest();
    reg_wr(8'h04, 32'h40);
    repeat (9) take(cls_vec_call, 6'd40, 20'h010a0, 20'h010a0, 1'b1);
    check(32'(irq), 32'h1);
    repeat (9) ret(1'b1);
    reg_chk(8'h0c, 32'h9);
    reg_chk(8'h00, 32'h48);
    $display("test nesting done");
  endtask

  // =====================================================================
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_vcall();
    t_traps();
    t_irq();
    t_nest();
    wrap_up();
  end
endmodule

// >>> swi_defs.svh
`ifndef SWI_DEFS_SVH
`define SWI_DEFS_SVH
// =====================================================================
// register offsets (byte addresses, one 32-bit word each)
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_VBASE 8'h08
`define REG_STATE 8'h0c
// =====================================================================
// reset values
`define VBASE_RST 20'h00000
`define MASK_RST 7'h00
// =====================================================================
// fixed vector addresses and break redirect marker
`define VEC_UND 20'hfffdc
`define VEC_OVF 20'hfffe0
`define VEC_BRK 20'hfffe4
`define VEC_NMI 20'hffff8
`define VEC_REDIRECT 8'hff
// =====================================================================
// numbered vectors: 256-byte table, 4 bytes a vector, 0..31 shared
`define TABLE_BYTES 256
`define SHARED_LAST 6'd31
// =====================================================================
// event bit positions in status and mask
`define EV_UND 0
`define EV_OVF 1
`define EV_BRK 2
`define EV_INTN 3
`define EV_NMI 4
`define EV_MASKABLE 5
`define EV_STK_OVF 6
`define EV_W 7
`endif

// >>> swi_link_if.sv
`timescale 1ns/10ps
// carrier between the trap unit and its stack and event helpers
interface swi_link_if #(parameter int EW = 7, parameter int SW = 2);
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [SW-1:0] push_data;
  logic [SW-1:0] top_data;
  logic [EW-1:0] ev_set;
  logic [EW-1:0] status;
  logic [EW-1:0] mask;
  logic [EW-1:0] mask_wd;
  logic clr_rd;
  logic mask_we;
  logic irq;
  modport stk_user(output push, pop, push_data, input full, empty, top_data);
  modport stk_side(input push, pop, push_data, output full, empty, top_data);
  modport evt_user(output ev_set, clr_rd, mask_we, mask_wd, input status, mask, irq);
  modport evt_side(input ev_set, clr_rd, mask_we, mask_wd, output status, mask, irq);
endinterface

// >>> swi_pkg.sv
package swi_pkg;
  // class of the instruction that the decoder reports as completed
  typedef enum logic [2:0] {
    cls_none, cls_undef, cls_ovf_trap, cls_break, cls_vec_call, cls_return
  } instr_class_e;
  // arithmetic operations, only some of which touch the overflow flag
  typedef enum logic [3:0] {
    op_other, op_abs, op_add, op_adc, op_adcf, op_cmp, op_div, op_divu,
    op_divx, op_neg, op_rmpa, op_sbb, op_sha, op_sub, op_logic
  } alu_op_e;
  // vector fetch sequence
  typedef enum logic [1:0] {s_idle, s_fetch, s_redirect} seq_state_e;
endpackage

// >>> swi_trap_unit.sv
// What this block does
// - maskable request taken only with gate flag set and level above core level
// - nmi taken regardless of gate flag, above any level setting
// - instruction traps are raised by execution and never masked
// - undefined-opcode trap always raises the undefined instruction interrupt
// - overflow trap raises its interrupt only when overflow flag is 1
// - overflow flag updated by listed arithmetic instructions only
// - break instruction always raises the break interrupt
// - vector call takes numbers 0 to 63 and raises that interrupt
// - numbers 0 to 31 share vectors with peripheral requests
// - for 0 to 31, save stack-select flag and clear it before the sequence
// - return from such a handler restores the saved stack-select flag; a return at which an interrupt is accepted neither pops nor restores
// - numbers 32 to 63 leave the stack-select flag unchanged
// - numbered vectors sit at base plus four times n in 256 bytes
// - fixed trap vectors; break vector holding ff redirects through the table
`timescale 1ns/10ps
`include "swi_defs.svh"
module swi_trap_unit
  import swi_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic instr_done,
  input instr_class_e instr_class,
  input wire logic [5:0] int_num,
  input wire logic alu_done,
  input alu_op_e alu_op,
  input wire logic alu_ov,
  input wire logic gate_flag,
  input wire logic [2:0] cpu_level,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic [4:0] irq_num,
  input wire logic nmi_req,
  input wire logic u_wr,
  input wire logic u_wdata,
  input wire logic [31:0] vec_rdata,
  input wire logic vec_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic stall,
  output logic vec_req,
  output logic [19:0] vec_addr,
  output logic handler_valid,
  output logic [19:0] handler_addr,
  output logic irq_ack,
  output logic stack_sel,
  output logic ov_flag,
  output logic irq
);
  swi_link_if #(.EW(`EV_W), .SW(2)) link();

  seq_state_e st_q;
  logic [19:0] vbase_q;
  logic u_q;
  logic ov_q;
  logic is_brk_q;
  logic stall_q;
  logic vec_req_q;
  logic [19:0] vec_addr_q;
  logic handler_valid_q;
  logic [19:0] handler_addr_q;
  logic irq_ack_q;
  logic [31:0] rdata_q;
  logic idle;
  logic take_sw;
  logic take_nmi;
  logic take_mi;
  logic accept;
  logic switch_u;
  logic ret_pop;
  logic redirect_hit;
  logic [5:0] sel_num;
  logic [19:0] tbl_addr;
  logic [19:0] acc_addr;
  logic [`EV_W-1:0] ev_set;
  logic [31:0] rdata_d;

  // =====================================================================
  // helpers
  flag_stack #(.DEPTH(STACK_DEPTH), .W(2)) u_stack (
    .clock(clock),
    .reset(reset),
    .lk(link.stk_side)
  );

  event_reg #(.W(`EV_W)) u_events (
    .clock(clock),
    .reset(reset),
    .lk(link.evt_side)
  );

  // arithmetic operations that set the overflow flag
  function automatic logic is_ov_op(input alu_op_e op);
    case (op)
      op_abs, op_add, op_adc, op_adcf, op_cmp, op_div, op_divu,
      op_divx, op_neg, op_rmpa, op_sbb, op_sha, op_sub: is_ov_op = 1'b1;
      default: is_ov_op = 1'b0;
    endcase
  endfunction

  // =====================================================================
  // acceptance at the instruction boundary
  assign idle = (st_q == s_idle);

  // instruction traps come first: they belong to the instruction just done
  always_comb begin
    take_sw = 1'b0;
    if (instr_done && idle) begin
      case (instr_class)
        cls_undef: take_sw = 1'b1;
        cls_ovf_trap: take_sw = ov_q;
        cls_break: take_sw = 1'b1;
        cls_vec_call: take_sw = 1'b1;
        default: take_sw = 1'b0;
      endcase
    end
  end

  // traps ignore the gate flag; nmi ignores gate and levels
  assign take_nmi = instr_done && idle && nmi_req && !take_sw;
  assign take_mi = instr_done && idle && irq_req && !take_sw && !take_nmi &&
                   gate_flag && (irq_level > cpu_level);
  assign accept = take_sw || take_nmi || take_mi;

  // number used for the relocatable table
  assign sel_num = take_mi ? {1'b0, irq_num} : int_num;
  assign tbl_addr = vbase_q + 20'({sel_num, 2'b00});

  // stack switch only for the shared low numbers
  assign switch_u = take_mi ||
                    (take_sw && instr_class == cls_vec_call &&
                     int_num <= `SHARED_LAST);

  // vector address of the accepted request
  always_comb begin
    acc_addr = tbl_addr;
    if (take_sw) begin
      case (instr_class)
        cls_undef: acc_addr = `VEC_UND;
        cls_ovf_trap: acc_addr = `VEC_OVF;
        cls_break: acc_addr = `VEC_BRK;
        default: acc_addr = tbl_addr;
      endcase
    end else if (take_nmi) begin
      acc_addr = `VEC_NMI;
    end
  end

  // =====================================================================
  // overflow flag, written only by the arithmetic group
  always_ff @(posedge clock) begin
    if (reset) begin
      ov_q <= 1'b0;
    end else if (alu_done && is_ov_op(alu_op)) begin
      ov_q <= alu_ov;
    end
  end

  // =====================================================================
  // stack-select flag and its save stack
  assign ret_pop = instr_done && idle && instr_class == cls_return && !accept;
  assign link.push = accept;
  assign link.push_data = {switch_u, u_q};
  assign link.pop = ret_pop;

  // acceptance beats a return, which beats a plain software write
  always_ff @(posedge clock) begin
    if (reset) begin
      u_q <= 1'b0;
    end else if (accept) begin
      if (switch_u) begin
        u_q <= 1'b0;
      end
    end else if (ret_pop && !link.empty) begin
      if (link.top_data[1]) begin
        u_q <= link.top_data[0];
      end
    end else if (u_wr) begin
      u_q <= u_wdata;
    end
  end

  // =====================================================================
  // vector fetch sequence
  assign redirect_hit = is_brk_q && vec_rdata[7:0] == `VEC_REDIRECT;

  // one fetch outstanding at a time; the core stalls until the handler
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= s_idle;
      is_brk_q <= 1'b0;
      stall_q <= 1'b0;
      vec_req_q <= 1'b0;
      vec_addr_q <= '0;
      handler_valid_q <= 1'b0;
      handler_addr_q <= '0;
    end else begin
      vec_req_q <= 1'b0;
      handler_valid_q <= 1'b0;
      case (st_q)
        s_idle: begin
          if (accept) begin
            st_q <= s_fetch;
            stall_q <= 1'b1;
            vec_req_q <= 1'b1;
            vec_addr_q <= acc_addr;
            is_brk_q <= take_sw && instr_class == cls_break;
          end
        end
        s_fetch, s_redirect: begin
          if (vec_valid && st_q == s_fetch && redirect_hit) begin // only a first word redirects
            st_q <= s_redirect;
            vec_req_q <= 1'b1;
            vec_addr_q <= vbase_q;
          end else if (vec_valid) begin
            st_q <= s_idle;
            stall_q <= 1'b0;
            handler_valid_q <= 1'b1;
            handler_addr_q <= vec_rdata[19:0];
          end
        end
        default: begin
          st_q <= s_idle;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // acknowledge to the interrupt controller so it drops the request
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_ack_q <= 1'b0;
    end else begin
      irq_ack_q <= take_mi;
    end
  end

  // =====================================================================
  // events
  always_comb begin
    ev_set = '0;
    ev_set[`EV_UND] = take_sw && instr_class == cls_undef;
    ev_set[`EV_OVF] = take_sw && instr_class == cls_ovf_trap;
    ev_set[`EV_BRK] = take_sw && instr_class == cls_break;
    ev_set[`EV_INTN] = take_sw && instr_class == cls_vec_call;
    ev_set[`EV_NMI] = take_nmi;
    ev_set[`EV_MASKABLE] = take_mi;
    ev_set[`EV_STK_OVF] = accept && link.full;
  end
  assign link.ev_set = ev_set;
  assign link.clr_rd = reg_re && reg_addr == `REG_STATUS;
  assign link.mask_we = reg_we && reg_addr == `REG_MASK;
  assign link.mask_wd = reg_wdata[`EV_W-1:0];

  // =====================================================================
  // register port; the table base keeps word alignment
  always_ff @(posedge clock) begin
    if (reset) begin
      vbase_q <= `VBASE_RST;
    end else if (reg_we && reg_addr == `REG_VBASE) begin
      vbase_q <= {reg_wdata[19:2], 2'b00};
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      `REG_STATUS: rdata_d[`EV_W-1:0] = link.status;
      `REG_MASK: rdata_d[`EV_W-1:0] = link.mask;
      `REG_VBASE: rdata_d[19:0] = vbase_q;
      `REG_STATE: rdata_d[3:0] = {link.empty, stall_q, ov_q, u_q};
      default: rdata_d = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_re ? rdata_d : '0;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = rdata_q;
  assign stall = stall_q;
  assign vec_req = vec_req_q;
  assign vec_addr = vec_addr_q;
  assign handler_valid = handler_valid_q;
  assign handler_addr = handler_addr_q;
  assign irq_ack = irq_ack_q;
  assign stack_sel = u_q;
  assign ov_flag = ov_q;
  assign irq = link.irq;

  // =====================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_done(instr_class_e c);
    instr_done && idle && instr_class == c;
  endsequence

  sequence s_brk_marker;
    st_q == s_fetch && is_brk_q && vec_valid && vec_rdata[7:0] == `VEC_REDIRECT;
  endsequence

  AST_MASKABLE_GATE: assert property (
    irq_ack_q |-> $past(gate_flag) && $past(irq_level) > $past(cpu_level))
    else $error("maskable request taken while gated or at low level");
  AST_NMI_UNGATED: assert property (
    s_done(cls_none) && nmi_req |=> vec_req_q && vec_addr_q == `VEC_NMI && stall_q)
    else $error("nmi not taken at instruction end");
  AST_UND_VECTOR: assert property (
    s_done(cls_undef) |=> vec_req_q && vec_addr_q == `VEC_UND)
    else $error("undefined trap did not fetch its vector");
  AST_OVF_CLEAR: assert property (
    s_done(cls_ovf_trap) && !ov_q && !nmi_req && !irq_req |=> !vec_req_q && !stall_q)
    else $error("overflow trap taken with flag clear");
  AST_OVF_SET: assert property (
    s_done(cls_ovf_trap) && ov_q |=> vec_req_q && vec_addr_q == `VEC_OVF)
    else $error("overflow trap missed with flag set");
  AST_OV_UPDATE: assert property (
    alu_done && !is_ov_op(alu_op) |=> ov_q == $past(ov_q))
    else $error("overflow flag changed by a non-arithmetic op");
  AST_BRK_VECTOR: assert property (
    s_done(cls_break) |=> vec_req_q && vec_addr_q == `VEC_BRK ##1 stall_q)
    else $error("break trap did not fetch its vector");
  AST_CALL_TABLE: assert property (
    s_done(cls_vec_call) |=>
      vec_addr_q == $past(vbase_q) + 20'({$past(int_num), 2'b00}))
    else $error("vector call fetched the wrong table entry");
  AST_LOW_SWITCH: assert property (
    s_done(cls_vec_call) && int_num <= `SHARED_LAST |=> !u_q && !link.empty)
    else $error("low vector call kept the user stack");
  AST_HIGH_KEEP: assert property (
    s_done(cls_vec_call) && int_num > `SHARED_LAST |=> u_q == $past(u_q))
    else $error("high vector call switched the stack");
  AST_RET_RESTORE: assert property (
    ret_pop && !link.empty && link.top_data[1] |=> u_q == $past(link.top_data[0]))
    else $error("return did not restore the stack-select flag");
  AST_BRK_REDIRECT: assert property (
    s_brk_marker |=> vec_req_q && vec_addr_q == vbase_q && st_q == s_redirect)
    else $error("break redirect did not use the table base");
  AST_STALL_HOLD: assert property (
    accept |=> stall_q[*2] or (stall_q ##1 handler_valid_q))
    else $error("core not held during the interrupt sequence");
endmodule

// >>> vec_mem_model.sv
`timescale 1ns/10ps
// =====================================================================
// vector memory behind the trap unit: answers each fetch after a delay
module vec_mem_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic vec_req,
  input wire logic [19:0] vec_addr,
  input wire logic redirect_brk,
  input wire logic slow,
  output logic vec_valid,
  output logic [31:0] vec_rdata
);
  logic [2:0] wait_q;
  logic [19:0] addr_q;
  // idle data flips every cycle so a stale word never passes for an answer
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_q <= 3'h0;
      addr_q <= 20'h00000;
      vec_valid <= 1'b0;
      vec_rdata <= 32'h00000000;
    end else if (vec_req) begin
      wait_q <= slow ? 3'h4 : 3'h1; // slow mode stretches the fetch
      addr_q <= vec_addr;
      vec_valid <= 1'b0;
      vec_rdata <= ~vec_rdata;
    end else if (wait_q == 3'h1) begin
      wait_q <= 3'h0;
      vec_valid <= 1'b1;
      vec_rdata <= (redirect_brk && addr_q == 20'hfffe4) ? 32'h000000ff :
                   {12'h000, addr_q ^ 20'h5a5a5};
    end else begin
      wait_q <= (wait_q == 3'h0) ? 3'h0 : wait_q - 3'h1;
      vec_valid <= 1'b0;
      vec_rdata <= ~vec_rdata;
    end
  end
endmodule
